/* File: logic/ship_switch_map.svh */
`ifndef SHIP_SWITCH_MAP_SVH
`define SHIP_SWITCH_MAP_SVH

// Clock rate in kHz, so a time in ms times this gives cycles.
`define SSW_CLOCK_KHZ 25000
// Printed times in milliseconds.
`define SSW_POWER_RESET_OFF_MS 350
`define SSW_SHIP_OFF_DELAY_MS 10000
`define SSW_EXIT_HOLD_LONG_MS 1000
`define SSW_EXIT_HOLD_SHORT_MS 15
`define SSW_RESET_HOLD_MS 10000
// Control field encodings and reset value.
`define SSW_MODE_IDLE 2'h0
`define SSW_MODE_SHUTDOWN 2'h1
`define SSW_MODE_SHIP 2'h2
`define SSW_MODE_POWER_RESET 2'h3
`define SSW_CONTROL_RESET 2'h0
// Width of the shared timer and of the wake hold counter.
`define SSW_TIMER_W 28

`endif

/* File: logic/ship_switch_mode_controller.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ship_switch_map.svh"

// Summary of operation
// - Field resets to 00: switch on, host on.
// - Idle: battery switch follows charging state.
// - Field 01: switch off, host off, shutdown.
// - Shutdown write with bus high reverts to 00.
// - Leaving shutdown restores field to 00.
// - Field 10: both switches off, slow clock.
// - Ship write with bus high reverts to 00.
// - Ship exits: adapter, 00, defaults, wake hold.
// - Ship exit reconnects battery, field back 00.
// - Field 11: switch off 350ms, then 00.
// - Wake held low 10s in idle starts power reset.
// - Power reset: high impedance if bus, sink.
// - Leaving 00 turns off now or after 10s.
module ship_switch_mode_controller
    import ship_switch_pkg::*;
#(
    parameter int unsigned POWER_RESET_CYCLES = `SSW_POWER_RESET_OFF_MS * `SSW_CLOCK_KHZ,
    parameter int unsigned OFF_DELAY_CYCLES = `SSW_SHIP_OFF_DELAY_MS * `SSW_CLOCK_KHZ,
    parameter int unsigned EXIT_LONG_CYCLES = `SSW_EXIT_HOLD_LONG_MS * `SSW_CLOCK_KHZ,
    parameter int unsigned EXIT_SHORT_CYCLES = `SSW_EXIT_HOLD_SHORT_MS * `SSW_CLOCK_KHZ,
    parameter int unsigned RESET_HOLD_CYCLES = `SSW_RESET_HOLD_MS * `SSW_CLOCK_KHZ
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic control_write,
    input wire logic [1:0] control_write_data,
    input wire logic defaults_restore,
    input wire logic ship_off_delay_select,
    input wire logic wake_hold_time_select,
    input wire logic charge_battery_on,
    input wire logic bus_supply_high,
    input wire logic wake_button_n,
    output logic [1:0] ship_switch_control,
    output logic external_ship_switch,
    output logic internal_battery_switch,
    output logic host_interface_enable,
    output logic slow_clock,
    output logic input_high_impedance,
    output logic sys_sink_enable
);

    localparam int TW = `SSW_TIMER_W;
    localparam logic [TW-1:0] RESET_LAST = TW'(POWER_RESET_CYCLES - 1);
    localparam logic [TW-1:0] DELAY_LAST = TW'(OFF_DELAY_CYCLES - 1);
    localparam logic [TW-1:0] LONG_LAST = TW'(EXIT_LONG_CYCLES - 1);
    localparam logic [TW-1:0] SHORT_LAST = TW'(EXIT_SHORT_CYCLES - 1);
    localparam logic [TW-1:0] HOLD_LAST = TW'(RESET_HOLD_CYCLES - 1);

    ssw_state_t state;
    logic [1:0] field;
    logic [TW-1:0] timer;
    logic [TW-1:0] wake_count;
    logic [1:0] wake_sync;
    logic [1:0] bus_sync;
    power_drive_t drive;
    logic wake_low;
    logic bus_high;
    logic exit_hold_done;
    logic reset_hold_done;
    logic leaving_idle;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is read by logic.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wake_sync <= 2'h3;
            bus_sync <= 2'h0;
        end else begin
            wake_sync <= {wake_sync[0], wake_button_n};
            bus_sync <= {bus_sync[0], bus_supply_high};
        end
    end

    assign wake_low = !wake_sync[1];
    assign bus_high = bus_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Wake hold counter saturates so a held button fires each event only once.
    always_ff @(posedge clock) begin
        if (!resetn || !wake_low) begin
            wake_count <= {TW{1'b0}};
        end else if (wake_count != HOLD_LAST) begin
            wake_count <= wake_count + TW'(1);
        end
    end

    assign exit_hold_done = wake_low && (wake_count == (wake_hold_time_select ? LONG_LAST
                                                                             : SHORT_LAST));
    assign reset_hold_done = wake_low && (wake_count == HOLD_LAST - TW'(1));
    assign leaving_idle = control_write && control_write_data != `SSW_MODE_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode sequencer and control field. The host interface is off in shutdown,
    // so writes are ignored there and only an adapter brings the device back.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= ST_IDLE;
            field <= `SSW_CONTROL_RESET;
            timer <= {TW{1'b0}};
        end else begin
            timer <= timer + TW'(1);
            case (state)
                ST_IDLE: begin
                    timer <= {TW{1'b0}};
                    if (reset_hold_done) begin
                        state <= ST_POWER_RESET;
                        field <= `SSW_MODE_POWER_RESET;
                    end else if (leaving_idle) begin
                        if (bus_high && control_write_data != `SSW_MODE_POWER_RESET) begin
                            field <= `SSW_MODE_IDLE;
                        end else begin
                            field <= control_write_data;
                            if (ship_off_delay_select) begin
                                state <= ST_DELAY;
                            end else if (control_write_data == `SSW_MODE_SHUTDOWN) begin
                                state <= ST_SHUTDOWN;
                            end else if (control_write_data == `SSW_MODE_SHIP) begin
                                state <= ST_SHIP;
                            end else begin
                                state <= ST_POWER_RESET;
                            end
                        end
                    end
                end
                ST_DELAY: begin
                    // A cancel, or an adapter unless a power reset is pending, drops back to idle during the wait.
                    if (defaults_restore || (control_write && control_write_data == 2'h0)
                        || (bus_high && field != `SSW_MODE_POWER_RESET)) begin
                        state <= ST_IDLE;
                        field <= `SSW_MODE_IDLE;
                    end else if (timer == DELAY_LAST) begin
                        timer <= {TW{1'b0}};
                        if (field == `SSW_MODE_SHUTDOWN) begin
                            state <= ST_SHUTDOWN;
                        end else if (field == `SSW_MODE_SHIP) begin
                            state <= ST_SHIP;
                        end else begin
                            state <= ST_POWER_RESET;
                        end
                    end
                end
                ST_SHUTDOWN: begin
                    if (bus_high) begin
                        state <= ST_IDLE;
                        field <= `SSW_MODE_IDLE;
                    end
                end
                ST_SHIP: begin
                    if (bus_high || defaults_restore || exit_hold_done
                        || (control_write && control_write_data == `SSW_MODE_IDLE)) begin
                        state <= ST_IDLE;
                        field <= `SSW_MODE_IDLE;
                    end
                end
                ST_POWER_RESET: begin
                    if (timer == RESET_LAST) begin
                        state <= ST_IDLE;
                        field <= `SSW_MODE_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    field <= `SSW_CONTROL_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output drive registered from the state, one cycle behind it.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            drive <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        end else begin
            drive.external_ship_switch <= state == ST_IDLE || state == ST_DELAY;
            drive.host_interface_enable <= state != ST_SHUTDOWN;
            drive.slow_clock <= state == ST_SHIP;
            drive.input_high_impedance <= state == ST_POWER_RESET && bus_high;
            drive.sys_sink_enable <= state == ST_POWER_RESET;
            // The battery switch is frozen during a power reset.
            if (state == ST_IDLE || state == ST_DELAY) begin
                drive.internal_battery_switch <= charge_battery_on;
            end else if (state != ST_POWER_RESET) begin
                drive.internal_battery_switch <= 1'b0;
            end
        end
    end

    assign ship_switch_control = field;
    assign external_ship_switch = drive.external_ship_switch;
    assign internal_battery_switch = drive.internal_battery_switch;
    assign host_interface_enable = drive.host_interface_enable;
    assign slow_clock = drive.slow_clock;
    assign input_high_impedance = drive.input_high_impedance;
    assign sys_sink_enable = drive.sys_sink_enable;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the sequencer and its outputs.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_ship_request_clear;
        state == ST_IDLE && !reset_hold_done && control_write
            && control_write_data == `SSW_MODE_SHIP && !bus_high && !ship_off_delay_select;
    endsequence

    sequence s_ship_then_off;
        state == ST_SHIP ##1 !external_ship_switch && !internal_battery_switch;
    endsequence

    a_idle_outputs: assert property (state == ST_IDLE |=> external_ship_switch
        && host_interface_enable && internal_battery_switch == $past(charge_battery_on))
        else $error("idle outputs wrong");
    a_shutdown_block: assert property (state == ST_IDLE && !reset_hold_done
        && control_write && control_write_data == `SSW_MODE_SHUTDOWN && bus_high
        |=> state == ST_IDLE && field == 2'h0)
        else $error("shutdown taken with bus high");
    a_ship_block: assert property (state == ST_IDLE && !reset_hold_done
        && control_write && control_write_data == `SSW_MODE_SHIP && bus_high
        |=> field == 2'h0 ##1 state == ST_IDLE)
        else $error("ship taken with bus high");
    a_shutdown_outputs: assert property (state == ST_SHUTDOWN |=>
        !external_ship_switch && !host_interface_enable)
        else $error("shutdown outputs wrong");
    a_shutdown_exit: assert property (state == ST_SHUTDOWN && bus_high |=>
        state == ST_IDLE && field == 2'h0)
        else $error("shutdown exit wrong");
    a_ship_immediate: assert property (s_ship_request_clear |=> s_ship_then_off)
        else $error("ship not entered at once");
    a_ship_outputs: assert property (state == ST_SHIP |=>
        slow_clock && host_interface_enable)
        else $error("ship outputs wrong");
    a_ship_wake: assert property (state == ST_SHIP && exit_hold_done |=>
        state == ST_IDLE && field == 2'h0 ##1 external_ship_switch)
        else $error("wake did not end ship");
    a_ship_adapter: assert property (state == ST_SHIP && bus_high |=>
        state == ST_IDLE ##1 external_ship_switch
        && internal_battery_switch == $past(charge_battery_on))
        else $error("adapter did not end ship");
    a_reset_end: assert property (state == ST_POWER_RESET && timer == RESET_LAST |=>
        state == ST_IDLE && field == 2'h0 ##1 external_ship_switch && !sys_sink_enable)
        else $error("power reset end wrong");
    a_reset_battery: assert property (state == ST_POWER_RESET ##1
        state == ST_POWER_RESET |-> $stable(internal_battery_switch))
        else $error("battery switch moved in reset");
    a_long_press: assert property (state == ST_IDLE && reset_hold_done |=>
        state == ST_POWER_RESET ##1 !external_ship_switch)
        else $error("long press ignored");
    a_reset_hiz: assert property (state == ST_POWER_RESET |=> sys_sink_enable
        && input_high_impedance == $past(bus_high))
        else $error("power reset drive wrong");
    a_wake_clear: assert property (!wake_low |=> wake_count == {TW{1'b0}})
        else $error("wake count not cleared");

endmodule
`default_nettype wire

/* File: logic/ship_switch_pkg.sv */
`default_nettype none

package ship_switch_pkg;
    // Gray codes along idle -> delay -> ship -> shutdown -> power reset.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DELAY = 3'h1,
        ST_SHIP = 3'h3,
        ST_SHUTDOWN = 3'h2,
        ST_POWER_RESET = 3'h6
    } ssw_state_t;

    // Drive bundle for the power path outputs.
    typedef struct packed {
        logic external_ship_switch;
        logic internal_battery_switch;
        logic host_interface_enable;
        logic slow_clock;
        logic input_high_impedance;
        logic sys_sink_enable;
    } power_drive_t;
endpackage

`default_nettype wire

/* File: verification/tb_ship_switch_mode_controller.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_ship_switch_mode_controller
    import ship_switch_pkg::*;
;
    logic clock, resetn, control_write, defaults_restore, ship_off_delay_select;
    logic wake_hold_time_select, charge_battery_on, bus_supply_high, wake_button_n, press;
    logic [1:0] control_write_data, ship_switch_control;
    logic [7:0] hold_cycles, now;
    // A net, since each member is driven by its own output port.
    wire power_drive_t drive;
    int fail_count, checks;

    ////////////////////////////////////////////////////////////////////////
    // Short counts keep the run brief; every expectation below uses them.
    ship_switch_mode_controller #(.POWER_RESET_CYCLES(20), .OFF_DELAY_CYCLES(30),
        .EXIT_LONG_CYCLES(40), .EXIT_SHORT_CYCLES(10), .RESET_HOLD_CYCLES(60)) DUT (
        .clock(clock), .resetn(resetn), .control_write(control_write),
        .control_write_data(control_write_data), .defaults_restore(defaults_restore),
        .ship_off_delay_select(ship_off_delay_select),
        .wake_hold_time_select(wake_hold_time_select),
        .charge_battery_on(charge_battery_on), .bus_supply_high(bus_supply_high),
        .wake_button_n(wake_button_n), .ship_switch_control(ship_switch_control),
        .external_ship_switch(drive.external_ship_switch),
        .internal_battery_switch(drive.internal_battery_switch),
        .host_interface_enable(drive.host_interface_enable), .slow_clock(drive.slow_clock),
        .input_high_impedance(drive.input_high_impedance),
        .sys_sink_enable(drive.sys_sink_enable));
    wake_button_model button (.clock(clock), .resetn(resetn), .press(press),
        .hold_cycles(hold_cycles), .wake_button_n(wake_button_n));

    // Field, then ship, battery, host, slow clock, high impedance, sink.
    assign now = {ship_switch_control, drive};

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One-cycle write strobe to the mode field.
    task automatic wr(input logic [1:0] v);
        @(posedge clock);
        control_write <= 1'b1;
        control_write_data <= v;
        @(posedge clock);
        control_write <= 1'b0;
        tick(3);
    endtask

    // Hold the wake pin low for n cycles, then let sync and logic settle.
    task automatic push(input int n);
        @(posedge clock);
        press <= 1'b1;
        hold_cycles <= 8'(n);
        @(posedge clock);
        press <= 1'b0;
        tick(n + 4);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 60 && ship_switch_control !== 2'h0; i++) @(posedge clock);
        tick(3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Free-running clock at 25 MHz.
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Hang guard: the whole sequence needs well under a thousand cycles.
    initial begin
        tick(3000);
        fail_count++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        {resetn, control_write, defaults_restore, ship_off_delay_select, press} = 5'h00;
        {wake_hold_time_select, bus_supply_high} = 2'h0;
        charge_battery_on = 1'b1;
        control_write_data = 2'h0;
        hold_cycles = 8'h00;
        fail_count = 0;
        checks = 0;
        tick(8);
        resetn <= 1'b1;
        tick(3);
        chk(now, 8'h38);
        charge_battery_on <= 1'b0;
        tick(3);
        chk(now, 8'h28);
        charge_battery_on <= 1'b1;
        wr(2'h2);
        chk(now, 8'h8C);
        push(6);
        chk(now, 8'h8C);
        push(15);
        chk(now, 8'h38);
        wake_hold_time_select <= 1'b1;
        wr(2'h2);
        push(15);
        chk(now, 8'h8C);
        push(45);
        chk(now, 8'h38);
        wake_hold_time_select <= 1'b0;
        wr(2'h2);
        wr(2'h0);
        chk(now, 8'h38);
        wr(2'h2);
        defaults_restore <= 1'b1;
        tick(1);
        defaults_restore <= 1'b0;
        tick(3);
        chk(now, 8'h38);
        wr(2'h2);
        bus_supply_high <= 1'b1;
        tick(5);
        chk(now, 8'h38);
        wr(2'h2);
        chk(now, 8'h38);
        wr(2'h1);
        chk(now, 8'h38);
        wr(2'h3);
        chk(now, 8'hDB);
        wait_idle();
        chk(now, 8'h38);
        bus_supply_high <= 1'b0;
        tick(4);
        wr(2'h1);
        chk(now, 8'h40);
        bus_supply_high <= 1'b1;
        tick(5);
        chk(now, 8'h38);
        bus_supply_high <= 1'b0;
        tick(4);
        push(70);
        chk(now, 8'hD9);
        wait_idle();
        chk(now, 8'h38);
        ship_off_delay_select <= 1'b1;
        wr(2'h2);
        chk({7'h00, drive.external_ship_switch}, 8'h01);
        tick(35);
        chk(now, 8'h8C);
        wr(2'h0);
        wr(2'h2);
        wr(2'h0);
        tick(40);
        chk(now, 8'h38);
        // A reset in mid-run must drop ship mode back to the power-on state.
        ship_off_delay_select <= 1'b0;
        wr(2'h2);
        chk(now, 8'h8C);
        resetn <= 1'b0;
        tick(2);
        resetn <= 1'b1;
        tick(2);
        chk(now, 8'h38);
        print_verdict();
    end
endmodule

`default_nettype wire

/* File: verification/wake_button_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Stands in for the user's wake pushbutton on the pin with the pull-up.
module wake_button_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic press,
    input wire logic [7:0] hold_cycles,
    output logic wake_button_n
);
    logic [7:0] remaining;

    // A press loads the hold span; the pin is low until the span runs out.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            remaining <= 8'h00;
        end else if (press) begin
            remaining <= hold_cycles;
        end else if (remaining != 8'h00) begin
            remaining <= remaining - 8'h01;
        end
    end

    // Released, the pull-up returns the pin high, never the last driven level.
    assign wake_button_n = (remaining == 8'h00);
endmodule

`default_nettype wire
